/* File: pmc_pkg.sv */
/*
 * Package for the power mode controller: register offsets, field
 * positions, reset values, mode encodings and carrier structs.
 * Assumes a 32-bit APB slave on a single 200 MHz system clock.
 */
package pmc_pkg;

	localparam logic [7:0] ADDR_POWER_CONTROL  = 8'h00;
	localparam logic [7:0] ADDR_POWER_CONTROL2 = 8'h04;
	localparam logic [7:0] ADDR_REGULATOR_MODE = 8'h08;
	localparam logic [7:0] ADDR_CLOCK_SELECT   = 8'h0C;
	localparam logic [7:0] ADDR_WAKE_ENABLE    = 8'h10;
	localparam logic [7:0] ADDR_PORT_MATCH     = 8'h14;
	localparam logic [7:0] ADDR_PORT_MASK      = 8'h18;
	localparam logic [7:0] ADDR_STATUS         = 8'h1C;

	// Power control fields
	localparam int IDLE_BIT    = 0;
	localparam int STOP_BIT    = 1;
	// Secondary power control fields
	localparam int SUSPEND_BIT = 0;
	localparam int SNOOZE_BIT  = 1;
	// Regulator mode fields
	localparam int DEEP_OFF_BIT = 0;
	localparam int CMP_KEEP_BIT = 1;
	// Clock select field: value selecting the 24.5 MHz oscillator
	localparam int              CLK_SEL_W     = 2;
	localparam logic [1:0]      CLK_SEL_24M   = 2'h1;
	localparam logic [1:0]      CLK_SEL_RESET = 2'h1;

	localparam int PORT_W = 8;
	localparam int WAKE_W = 8;
	// Wake source index shared by the port-match event and WAKE_SRC[0]
	localparam int WAKE_PORT_MATCH = 0;

	localparam logic [PORT_W-1:0] PORT_MATCH_RESET = 8'h00;
	localparam logic [PORT_W-1:0] PORT_MASK_RESET  = 8'h00;
	localparam logic [WAKE_W-1:0] WAKE_EN_RESET    = 8'h00;

	// Status register field positions
	localparam int ST_MODE_LSB  = 0;
	localparam int ST_LDO_LSB   = 8;
	localparam int ST_MATCH_BIT = 12;

	typedef enum logic [5:0] {
		PMC_NORMAL   = 6'h01,
		PMC_IDLE     = 6'h02,
		PMC_SUSPEND  = 6'h04,
		PMC_SNOOZE   = 6'h08,
		PMC_STOP     = 6'h10,
		PMC_SHUTDOWN = 6'h20
	} pmc_mode_t;

	// Power side controls: core run, fast oscillators, regulator
	typedef struct packed {
		logic core_run;
		logic hfosc_en;
		logic clk_en;
		logic ldo_on;
		logic ldo_low_bias;
		logic cmp_on;
		logic analog_on;
		logic pin_hold;
	} pmc_pwr_t;

	// Power controls as they stand in normal mode and during reset
	localparam pmc_pwr_t PWR_RESET = '{core_run: 1'b1, hfosc_en: 1'b1,
		clk_en: 1'b1, ldo_on: 1'b1, ldo_low_bias: 1'b0, cmp_on: 1'b1,
		analog_on: 1'b1, pin_hold: 1'b0};

	typedef struct packed {
		logic [7:0]  paddr;
		logic        psel;
		logic        penable;
		logic        pwrite;
		logic [31:0] pwdata;
	} pmc_apb_req_t;

endpackage

/* File: pmc_port_match.sv */
/*
 * Port match detector: flags a pin that differs from its match value
 * on any bit whose mask bit is set. Assumes pins are synchronous to the clock.
 */
module pmc_port_match (
	input  wire logic                       clk,
	input  wire logic                       rst_n,
	input  wire logic                       ce,
	input  wire logic [pmc_pkg::PORT_W-1:0] pins,
	input  wire logic [pmc_pkg::PORT_W-1:0] match_val,
	input  wire logic [pmc_pkg::PORT_W-1:0] mask,
	output logic                            hit
);

	typedef struct packed {
		logic hit_ff;
	} pmc_pm_state_t;

	pmc_pm_state_t st_ff;
	pmc_pm_state_t nxt_st;
	logic [pmc_pkg::PORT_W-1:0] bit_hit;

	genvar g;
	generate
		for (g = 0; g < pmc_pkg::PORT_W; g++) begin : g_bit
			assign bit_hit[g] = mask[g] & (pins[g] ^ match_val[g]);
		end
	endgenerate

	always_comb begin
		nxt_st = st_ff;
		nxt_st.hit_ff = |bit_hit;
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			st_ff <= '0;
		end else if (ce) begin
			st_ff <= nxt_st;
		end
	end

	assign hit = st_ff.hit_ff;

endmodule

/* File: pmc_top.sv */
/*
 * Power mode controller: sequences normal, idle, suspend, snooze, stop
 * and shutdown; drives core, clock, regulator and pin-hold controls;
 * holds the mode registers on an APB slave.
 * Assumes one 200 MHz clock, an asynchronous active-low reset that
 * combines power-on, pin and supply-monitor resets, and interrupt and
 * wake levels synchronous to the clock.
 */

// Notes on behaviour
// R1 - Idle bit halts core, peripherals run
// R2 - Idle exits on enabled interrupt or reset
// R3 - Software selects 24.5 MHz before suspend
// R4 - Suspend: core halted, oscillators off, normal bias
// R5 - Software selects 24.5 MHz before snooze
// R6 - Snooze: core halted, oscillators off, low bias
// R7 - Only enabled peripherals wake from suspend/snooze
// R8 - Suspend/snooze exit on wake or reset
// R9 - Stop: clocks off, regulator on, pins held
// R10 - Stop with deep-off enters shutdown
// R11 - Shutdown ends only on pin/power-on reset
// R12 - Supply monitor low holds device reset
// R13 - Regulator low-current in snooze, off in shutdown
// R14 - Port match wakes or raises interrupt
// R15 - Software may slow clock in normal/idle
// R16 - Wake restarts oscillators, resumes after request
module pmc_top (
	input  wire logic                       SYS_CLK,
	input  wire logic                       RESETN,
	input  wire logic                       CLK_EN,
	input  wire logic                       PIN_RESET_N,
	input  wire logic                       SUPPLY_OK,
	input  wire logic                       OTHER_RESET,
	input  wire logic                       IRQ_PENDING,
	input  wire logic [pmc_pkg::WAKE_W-1:0] WAKE_SRC,
	input  wire logic [pmc_pkg::PORT_W-1:0] PORT_PINS,
	input  wire logic [7:0]                 PADDR,
	input  wire logic                       PSEL,
	input  wire logic                       PENABLE,
	input  wire logic                       PWRITE,
	input  wire logic [31:0]                PWDATA,
	output logic [31:0]                     PRDATA,
	output logic                            PREADY,
	output logic                            PSLVERR,
	output logic                            CORE_RUN,
	output logic                            HFOSC_EN,
	output logic                            CLK_RUN,
	output logic                            LDO_ON,
	output logic                            LDO_LOW_BIAS,
	output logic                            CMP_ON,
	output logic                            ANALOG_ON,
	output logic                            PIN_HOLD,
	output logic                            SYS_RESET_N,
	output logic                            PORT_MATCH_IRQ,
	output logic [5:0]                      MODE
);

	typedef struct packed {
		pmc_pkg::pmc_mode_t                   mode_ff;
		logic                                 deep_off_ff;
		logic                                 cmp_keep_ff;
		logic [pmc_pkg::CLK_SEL_W-1:0]        clk_sel_ff;
		logic [pmc_pkg::WAKE_W-1:0]           wake_en_ff;
		logic [pmc_pkg::PORT_W-1:0]           match_ff;
		logic [pmc_pkg::PORT_W-1:0]           mask_ff;
		logic                                 match_flag_ff;
		logic                                 sys_rst_n_ff;
		pmc_pkg::pmc_pwr_t                    pwr_ff;
		logic [31:0]                          prdata_ff;
		logic                                 pready_ff;
		logic                                 pslverr_ff;
	} pmc_state_t;

	pmc_state_t          st_ff;
	pmc_state_t          nxt_st;
	pmc_pkg::pmc_apb_req_t req;
	logic                match_hit;
	logic                wr_acc;
	logic                rd_acc;
	logic                wake_any;
	logic                reset_any;
	logic [pmc_pkg::WAKE_W-1:0] wake_lane;

	pmc_port_match i_pmc_port_match (
		.clk       (SYS_CLK),
		.rst_n     (RESETN),
		.ce        (CLK_EN),
		.pins      (PORT_PINS),
		.match_val (st_ff.match_ff),
		.mask      (st_ff.mask_ff),
		.hit       (match_hit)
	);

	assign req.paddr   = PADDR;
	assign req.psel    = PSEL;
	assign req.penable = PENABLE;
	assign req.pwrite  = PWRITE;
	assign req.pwdata  = PWDATA;

	// Access completes one cycle into the access phase: one wait state, then pready rises
	assign wr_acc = req.psel & req.penable & req.pwrite & ~st_ff.pready_ff;
	assign rd_acc = req.psel & req.penable & ~req.pwrite & ~st_ff.pready_ff;

	// Port match shares wake lane 0 with WAKE_SRC[0], gated like any other source
	genvar w;
	generate
		for (w = 0; w < pmc_pkg::WAKE_W; w++) begin : g_wake
			if (w == pmc_pkg::WAKE_PORT_MATCH) begin : g_match
				assign wake_lane[w] = (WAKE_SRC[w] | match_hit)
					& st_ff.wake_en_ff[w]; // [R7] [R14]
			end else begin : g_src
				assign wake_lane[w] = WAKE_SRC[w] & st_ff.wake_en_ff[w]; // [R7]
			end
		end
	endgenerate
	assign wake_any = |wake_lane;
	// Soft resets (watchdog and the like) cannot end shutdown
	assign reset_any = OTHER_RESET | ~PIN_RESET_N | ~SUPPLY_OK;

	function automatic pmc_pkg::pmc_pwr_t pwr_for(
		input pmc_pkg::pmc_mode_t m,
		input logic               cmp_keep
	);
		pmc_pkg::pmc_pwr_t p;
		p = pmc_pkg::PWR_RESET;
		case (m)
			pmc_pkg::PMC_IDLE: begin
				// Oscillators and clocks keep running for the peripherals
				p.core_run = 1'b0; // [R1]
			end
			pmc_pkg::PMC_SUSPEND: begin
				// Normal bias is kept so that wake-up needs no settling
				p.core_run = 1'b0; // [R4]
				p.hfosc_en = 1'b0;
			end
			pmc_pkg::PMC_SNOOZE: begin
				p.core_run     = 1'b0; // [R6]
				p.hfosc_en     = 1'b0;
				p.ldo_low_bias = 1'b1; // [R13]
			end
			pmc_pkg::PMC_STOP: begin
				// Comparators may stay up to serve as a reset source
				p.core_run  = 1'b0; // [R9]
				p.hfosc_en  = 1'b0;
				p.clk_en    = 1'b0;
				p.cmp_on    = cmp_keep;
				p.analog_on = cmp_keep;
				p.pin_hold  = 1'b1;
			end
			pmc_pkg::PMC_SHUTDOWN: begin
				p.core_run  = 1'b0; // [R10]
				p.hfosc_en  = 1'b0;
				p.clk_en    = 1'b0;
				p.ldo_on    = 1'b0; // [R13]
				p.cmp_on    = 1'b0;
				p.analog_on = 1'b0;
				p.pin_hold  = 1'b1;
			end
			default: begin
				p.core_run = 1'b1;
			end
		endcase
		return p;
	endfunction

	always_comb begin
		nxt_st = st_ff;
		nxt_st.pready_ff  = wr_acc | rd_acc;
		nxt_st.pslverr_ff = 1'b0;
		// Supply low or any reset keeps the system in reset
		nxt_st.sys_rst_n_ff = ~reset_any; // [R12]
		// Set wins over a same-cycle software clear
		if (match_hit) begin
			nxt_st.match_flag_ff = 1'b1; // [R14]
		end

		// Requests are taken in normal mode only: in every other mode
		// the core is halted and cannot write
		case (st_ff.mode_ff)
			pmc_pkg::PMC_NORMAL: begin
				if (wr_acc && req.paddr == pmc_pkg::ADDR_POWER_CONTROL) begin
					if (req.pwdata[pmc_pkg::STOP_BIT]) begin
						nxt_st.mode_ff = st_ff.deep_off_ff
							? pmc_pkg::PMC_SHUTDOWN // [R10]
							: pmc_pkg::PMC_STOP; // [R9]
					end else if (req.pwdata[pmc_pkg::IDLE_BIT]) begin
						nxt_st.mode_ff = pmc_pkg::PMC_IDLE; // [R1]
					end
				end else if (wr_acc &&
					req.paddr == pmc_pkg::ADDR_POWER_CONTROL2) begin
					// Software is expected to select 24.5 MHz first
					if (req.pwdata[pmc_pkg::SNOOZE_BIT]) begin
						nxt_st.mode_ff = pmc_pkg::PMC_SNOOZE; // [R5]
					end else if (req.pwdata[pmc_pkg::SUSPEND_BIT]) begin
						nxt_st.mode_ff = pmc_pkg::PMC_SUSPEND; // [R3]
					end
				end
			end
			pmc_pkg::PMC_IDLE: begin
				// IRQ_PENDING already carries the interrupt enables
				if (IRQ_PENDING || wake_any || reset_any) begin
					nxt_st.mode_ff = pmc_pkg::PMC_NORMAL; // [R2] [R16]
				end
			end
			pmc_pkg::PMC_SUSPEND, pmc_pkg::PMC_SNOOZE: begin
				// An interrupt alone does not end these modes
				if (wake_any || reset_any) begin
					nxt_st.mode_ff = pmc_pkg::PMC_NORMAL; // [R8] [R16]
				end
			end
			pmc_pkg::PMC_STOP: begin
				// Wake lanes and interrupts are ignored: only a reset ends stop
				if (reset_any) begin
					nxt_st.mode_ff = pmc_pkg::PMC_NORMAL; // [R9]
				end
			end
			pmc_pkg::PMC_SHUTDOWN: begin
				// Regulator is off: only pin or power-on reset restarts
				if (!PIN_RESET_N || !SUPPLY_OK) begin
					nxt_st.mode_ff = pmc_pkg::PMC_NORMAL; // [R11]
				end
			end
			// A corrupt one-hot code falls back to normal
			default: begin
				nxt_st.mode_ff = pmc_pkg::PMC_NORMAL;
			end
		endcase

		// Power controls follow the next mode so they switch with MODE
		nxt_st.pwr_ff = pwr_for(nxt_st.mode_ff, st_ff.cmp_keep_ff);

		if (wr_acc) begin
			case (req.paddr)
				pmc_pkg::ADDR_REGULATOR_MODE: begin
					nxt_st.deep_off_ff = req.pwdata[pmc_pkg::DEEP_OFF_BIT];
					nxt_st.cmp_keep_ff = req.pwdata[pmc_pkg::CMP_KEEP_BIT];
				end
				pmc_pkg::ADDR_CLOCK_SELECT: begin
					nxt_st.clk_sel_ff = req.pwdata[pmc_pkg::CLK_SEL_W-1:0];
				end
				pmc_pkg::ADDR_WAKE_ENABLE: begin
					nxt_st.wake_en_ff = req.pwdata[pmc_pkg::WAKE_W-1:0];
				end
				pmc_pkg::ADDR_PORT_MATCH: begin
					nxt_st.match_ff = req.pwdata[pmc_pkg::PORT_W-1:0];
				end
				pmc_pkg::ADDR_PORT_MASK: begin
					nxt_st.mask_ff = req.pwdata[pmc_pkg::PORT_W-1:0];
				end
				pmc_pkg::ADDR_STATUS: begin
					if (req.pwdata[pmc_pkg::ST_MATCH_BIT] && !match_hit) begin
						nxt_st.match_flag_ff = 1'b0;
					end
				end
				pmc_pkg::ADDR_POWER_CONTROL,
				pmc_pkg::ADDR_POWER_CONTROL2: begin
					nxt_st.pslverr_ff = 1'b0;
				end
				// Unmapped offsets answer with an error and change nothing
				default: begin
					nxt_st.pslverr_ff = 1'b1;
				end
			endcase
		end

		if (rd_acc) begin
			nxt_st.prdata_ff = '0;
			case (req.paddr)
				pmc_pkg::ADDR_POWER_CONTROL,
				pmc_pkg::ADDR_POWER_CONTROL2: begin
					// Mode requests act at once, so these read back as zero
					nxt_st.prdata_ff = '0;
				end
				pmc_pkg::ADDR_REGULATOR_MODE: begin
					nxt_st.prdata_ff[pmc_pkg::DEEP_OFF_BIT] = st_ff.deep_off_ff;
					nxt_st.prdata_ff[pmc_pkg::CMP_KEEP_BIT] = st_ff.cmp_keep_ff;
				end
				pmc_pkg::ADDR_CLOCK_SELECT: begin
					nxt_st.prdata_ff[pmc_pkg::CLK_SEL_W-1:0] = st_ff.clk_sel_ff;
				end
				pmc_pkg::ADDR_WAKE_ENABLE: begin
					nxt_st.prdata_ff[pmc_pkg::WAKE_W-1:0] = st_ff.wake_en_ff;
				end
				pmc_pkg::ADDR_PORT_MATCH: begin
					nxt_st.prdata_ff[pmc_pkg::PORT_W-1:0] = st_ff.match_ff;
				end
				pmc_pkg::ADDR_PORT_MASK: begin
					nxt_st.prdata_ff[pmc_pkg::PORT_W-1:0] = st_ff.mask_ff;
				end
				pmc_pkg::ADDR_STATUS: begin
					nxt_st.prdata_ff[pmc_pkg::ST_MODE_LSB +:
						$bits(pmc_pkg::pmc_mode_t)] = st_ff.mode_ff;
					nxt_st.prdata_ff[pmc_pkg::ST_LDO_LSB] = st_ff.pwr_ff.ldo_on;
					nxt_st.prdata_ff[pmc_pkg::ST_LDO_LSB + 1] =
						st_ff.pwr_ff.ldo_low_bias;
					nxt_st.prdata_ff[pmc_pkg::ST_MATCH_BIT] = st_ff.match_flag_ff;
				end
				default: begin
					nxt_st.pslverr_ff = 1'b1;
				end
			endcase
		end
	end

	// Clock enable low freezes all state, APB included, so software may
	// slow the effective clock in normal and idle without side effects
	always_ff @(posedge SYS_CLK or negedge RESETN) begin
		if (!RESETN) begin
			st_ff <= '{
				mode_ff:       pmc_pkg::PMC_NORMAL,
				deep_off_ff:   1'b0,
				cmp_keep_ff:   1'b0,
				clk_sel_ff:    pmc_pkg::CLK_SEL_RESET,
				wake_en_ff:    pmc_pkg::WAKE_EN_RESET,
				match_ff:      pmc_pkg::PORT_MATCH_RESET,
				mask_ff:       pmc_pkg::PORT_MASK_RESET,
				match_flag_ff: 1'b0,
				// System reset stays asserted until the first clocked look
				sys_rst_n_ff:  1'b0,
				pwr_ff:        pmc_pkg::PWR_RESET,
				prdata_ff:     '0,
				pready_ff:     1'b0,
				pslverr_ff:    1'b0
			};
		end else if (CLK_EN) begin
			st_ff <= nxt_st;
		end
	end

	assign PRDATA         = st_ff.prdata_ff;
	assign PREADY         = st_ff.pready_ff;
	assign PSLVERR        = st_ff.pslverr_ff;
	assign CORE_RUN       = st_ff.pwr_ff.core_run;
	assign HFOSC_EN       = st_ff.pwr_ff.hfosc_en;
	assign CLK_RUN        = st_ff.pwr_ff.clk_en;
	assign LDO_ON         = st_ff.pwr_ff.ldo_on;
	assign LDO_LOW_BIAS   = st_ff.pwr_ff.ldo_low_bias;
	assign CMP_ON         = st_ff.pwr_ff.cmp_on;
	assign ANALOG_ON      = st_ff.pwr_ff.analog_on;
	assign PIN_HOLD       = st_ff.pwr_ff.pin_hold;
	assign SYS_RESET_N    = st_ff.sys_rst_n_ff;
	assign PORT_MATCH_IRQ = st_ff.match_flag_ff;
	assign MODE           = st_ff.mode_ff;

endmodule

/* File: pmc_top_props.sv */
/*
 * Checker for the power mode controller: power outputs per mode, mode
 * exits and the APB wait state.
 * Assumes it is bound to pmc_top and sees only that module's ports.
 */
module pmc_props (
	input wire logic        SYS_CLK,
	input wire logic        RESETN,
	input wire logic        CLK_EN,
	input wire logic        PIN_RESET_N,
	input wire logic        SUPPLY_OK,
	input wire logic        OTHER_RESET,
	input wire logic        IRQ_PENDING,
	input wire logic [7:0]  PADDR,
	input wire logic        PSEL,
	input wire logic        PENABLE,
	input wire logic        PWRITE,
	input wire logic [31:0] PWDATA,
	input wire logic        PREADY,
	input wire logic        CORE_RUN,
	input wire logic        HFOSC_EN,
	input wire logic        CLK_RUN,
	input wire logic        LDO_ON,
	input wire logic        LDO_LOW_BIAS,
	input wire logic        ANALOG_ON,
	input wire logic        PIN_HOLD,
	input wire logic        SYS_RESET_N,
	input wire logic [5:0]  MODE
);
	default clocking @(posedge SYS_CLK);
	endclocking
	default disable iff (!RESETN);

	sequence s_access;
		PSEL && PENABLE && !PREADY && CLK_EN;
	endsequence
	// Reset sources are excluded, though normal mode takes the request whatever they are
	sequence s_idle_req;
		s_access ##0 (PWRITE && PADDR == pmc_pkg::ADDR_POWER_CONTROL
			&& PWDATA[1:0] == 2'h1 && MODE == pmc_pkg::PMC_NORMAL
			&& PIN_RESET_N && SUPPLY_OK && !OTHER_RESET);
	endsequence

	chk_apb_wait: assert property (s_access |=> PREADY)
		else $error("no ready after access phase");
	chk_idle_entry: assert property (s_idle_req |=>
		MODE == pmc_pkg::PMC_IDLE && !CORE_RUN && HFOSC_EN && CLK_RUN)
		else $error("idle request not taken");
	chk_idle_exit: assert property (MODE == pmc_pkg::PMC_IDLE
		&& IRQ_PENDING && CLK_EN |=> MODE == pmc_pkg::PMC_NORMAL)
		else $error("idle kept despite interrupt");
	chk_suspend_bias: assert property (MODE == pmc_pkg::PMC_SUSPEND |->
		!CORE_RUN && !HFOSC_EN && LDO_ON && !LDO_LOW_BIAS)
		else $error("suspend outputs wrong");
	chk_snooze_bias: assert property (
		MODE == pmc_pkg::PMC_SNOOZE |->
		!CORE_RUN && !HFOSC_EN && LDO_ON && LDO_LOW_BIAS)
		else $error("snooze outputs wrong");
	chk_ce_freeze: assert property (!CLK_EN |=> $stable(MODE)
		&& $stable(PREADY) && $stable(SYS_RESET_N))
		else $error("state moved while clock enable low");
	chk_pin_exit: assert property (MODE != pmc_pkg::PMC_NORMAL
		&& !PIN_RESET_N && CLK_EN |=> MODE == pmc_pkg::PMC_NORMAL)
		else $error("pin reset did not end low power mode");
	chk_stop_outputs: assert property (MODE == pmc_pkg::PMC_STOP |->
		!CLK_RUN && !CORE_RUN && LDO_ON && PIN_HOLD)
		else $error("stop outputs wrong");
	chk_shut_outputs: assert property (MODE == pmc_pkg::PMC_SHUTDOWN |->
		!CLK_RUN && !LDO_ON && !ANALOG_ON && PIN_HOLD)
		else $error("shutdown outputs wrong");
	chk_shut_hold: assert property (MODE == pmc_pkg::PMC_SHUTDOWN
		&& PIN_RESET_N && SUPPLY_OK |=> MODE == pmc_pkg::PMC_SHUTDOWN)
		else $error("shutdown left without pin or power reset");
	chk_supply_reset: assert property (!SUPPLY_OK && CLK_EN
		|=> !SYS_RESET_N)
		else $error("low supply did not hold reset");
	chk_wake_resume: assert property (MODE == pmc_pkg::PMC_NORMAL |->
		CORE_RUN && HFOSC_EN && CLK_RUN)
		else $error("normal mode without core or oscillator");
endmodule

bind pmc_top pmc_props i_pmc_props (
	.SYS_CLK(SYS_CLK), .RESETN(RESETN), .CLK_EN(CLK_EN),
	.PIN_RESET_N(PIN_RESET_N), .SUPPLY_OK(SUPPLY_OK),
	.OTHER_RESET(OTHER_RESET), .IRQ_PENDING(IRQ_PENDING), .PADDR(PADDR),
	.PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE), .PWDATA(PWDATA),
	.PREADY(PREADY), .CORE_RUN(CORE_RUN), .HFOSC_EN(HFOSC_EN),
	.CLK_RUN(CLK_RUN), .LDO_ON(LDO_ON), .LDO_LOW_BIAS(LDO_LOW_BIAS),
	.ANALOG_ON(ANALOG_ON), .PIN_HOLD(PIN_HOLD),
	.SYS_RESET_N(SYS_RESET_N), .MODE(MODE)
);

/* File: tb_pmc_top.sv */
/*
 * Self-checking bench for the power mode controller.
 * Assumes the checker is bound separately; drives APB and wake inputs.
 */
module tb_pmc_top;
	timeunit 1ns;
	timeprecision 1ps;
	logic        clk, rst_n, pin_rst_n, sup_ok, oth_rst, irq, ce;
	logic        psel, pen, pwr, pready, pslverr, rerr;
	logic [7:0]  wake, pins, paddr;
	logic [31:0] pwdata, prdata, rdat, v;
	logic [31:0] seed = 32'h00002ABA;
	logic [5:0]  mode, lp;
	logic [7:0]  pwr_o;
	int          miscompares = 0;
	int          total_checks = 0;
	int          k;

	pmc_top i_pmc_top (.SYS_CLK(clk), .RESETN(rst_n), .CLK_EN(ce),
		.PIN_RESET_N(pin_rst_n), .SUPPLY_OK(sup_ok), .OTHER_RESET(oth_rst),
		.IRQ_PENDING(irq), .WAKE_SRC(wake), .PORT_PINS(pins),
		.PADDR(paddr), .PSEL(psel), .PENABLE(pen), .PWRITE(pwr),
		.PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
		.PSLVERR(pslverr), .CORE_RUN(pwr_o[7]), .HFOSC_EN(pwr_o[6]),
		.CLK_RUN(pwr_o[5]), .LDO_ON(pwr_o[4]), .LDO_LOW_BIAS(pwr_o[3]),
		.CMP_ON(pwr_o[2]), .ANALOG_ON(pwr_o[1]), .PIN_HOLD(pwr_o[0]),
		.SYS_RESET_N(), .PORT_MATCH_IRQ(), .MODE(mode));

	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction

	// Order: core, hfosc, clocks, ldo, low bias, cmp, analog, pin hold
	function automatic logic [7:0] exp_pwr(input logic [5:0] m,
		input logic keep);
		case (m)
			pmc_pkg::PMC_IDLE:     return 8'h76;
			pmc_pkg::PMC_SUSPEND:  return 8'h36;
			pmc_pkg::PMC_SNOOZE:   return 8'h3E;
			pmc_pkg::PMC_STOP:     return {5'h02, keep, keep, 1'b1};
			pmc_pkg::PMC_SHUTDOWN: return 8'h01;
			default:               return 8'hF6;
		endcase
	endfunction

	task automatic complete_run;
		if (miscompares == 0 && total_checks > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		total_checks++;
		if (seen !== exp) begin
			miscompares++;
			$display("ERROR %0t seen %h expected %h", $time, seen, exp);
		end
	endtask

	// Reads are taken at the edge where ready is sampled high
	task automatic apb(input logic wr, input logic [7:0] a,
		input logic [31:0] d);
		int n;
		@(posedge clk);
		psel <= 1'b1;
		paddr <= a;
		pwr <= wr;
		pwdata <= d;
		@(posedge clk);
		pen <= 1'b1;
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		rdat = prdata;
		rerr = pslverr;
		psel <= 1'b0;
		pen <= 1'b0;
		chk(32'(pready), 32'h1);
		if (pready !== 1'b1)
			complete_run;
	endtask

	task automatic chk_mode(input logic [5:0] m, input logic keep);
		chk(32'(mode), 32'(m));
		chk(32'(pwr_o), 32'(exp_pwr(m, keep)));
	endtask

	task automatic wait_mode(input logic [5:0] m);
		int n;
		for (n = 0; n < 4 && mode !== m; n++)
			@(posedge clk);
		chk_mode(m, 1'b0);
		if (mode !== m)
			complete_run;
	endtask

	initial begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end

	initial begin
		repeat (20000) @(posedge clk);
		miscompares++;
		complete_run;
	end

	initial begin
		{rst_n, oth_rst, irq, psel, pen, pwr} = '0;
		{pin_rst_n, sup_ok, ce} = 3'b111;
		{wake, pins, paddr, pwdata} = '0;
		repeat (12) @(posedge clk);
		rst_n <= 1'b1;
		@(posedge clk);
		chk_mode(pmc_pkg::PMC_NORMAL, 1'b1);
		apb(1'b0, pmc_pkg::ADDR_CLOCK_SELECT, 32'h0);
		chk(rdat, 32'(pmc_pkg::CLK_SEL_RESET));
		apb(1'b0, 8'h20, 32'h0);
		chk(32'(rerr), 32'h1);
		apb(1'b1, pmc_pkg::ADDR_POWER_CONTROL, 32'h1);
		chk_mode(pmc_pkg::PMC_IDLE, 1'b0);
		// A gated clock must hold back the pending exit
		ce <= 1'b0;
		irq <= 1'b1;
		repeat (3) @(posedge clk);
		chk_mode(pmc_pkg::PMC_IDLE, 1'b0);
		ce <= 1'b1;
		wait_mode(pmc_pkg::PMC_NORMAL);
		irq <= 1'b0;
		for (k = 0; k < 2; k++) begin
			v = rnd() & 32'h7F | 32'h02;
			apb(1'b1, pmc_pkg::ADDR_CLOCK_SELECT, 32'h1);
			apb(1'b1, pmc_pkg::ADDR_WAKE_ENABLE, v);
			apb(1'b1, pmc_pkg::ADDR_POWER_CONTROL2, 32'(k + 1));
			lp = k ? pmc_pkg::PMC_SNOOZE : pmc_pkg::PMC_SUSPEND;
			chk_mode(lp, 1'b0);
			wake <= 8'h80;
			repeat (4) @(posedge clk);
			chk_mode(lp, 1'b0);
			wake <= 8'h02;
			wait_mode(pmc_pkg::PMC_NORMAL);
			wake <= 8'h00;
		end
		// Stop and idle requested together: stop must win
		for (k = 0; k < 2; k++) begin
			apb(1'b1, pmc_pkg::ADDR_REGULATOR_MODE, 32'(k * 2));
			apb(1'b1, pmc_pkg::ADDR_POWER_CONTROL, 32'h3);
			{irq, wake} <= 9'h1FF;
			repeat (4) @(posedge clk);
			chk_mode(pmc_pkg::PMC_STOP, k[0]);
			{irq, wake} <= 9'h000;
			oth_rst <= 1'b1;
			wait_mode(pmc_pkg::PMC_NORMAL);
			oth_rst <= 1'b0;
		end
		apb(1'b1, pmc_pkg::ADDR_REGULATOR_MODE, 32'h1);
		apb(1'b1, pmc_pkg::ADDR_POWER_CONTROL, 32'h2);
		{oth_rst, irq, wake} <= 10'h3FF;
		repeat (4) @(posedge clk);
		chk_mode(pmc_pkg::PMC_SHUTDOWN, 1'b0);
		{oth_rst, irq, wake} <= 10'h000;
		pin_rst_n <= 1'b0;
		wait_mode(pmc_pkg::PMC_NORMAL);
		pin_rst_n <= 1'b1;
		sup_ok <= 1'b0;
		repeat (6) @(posedge clk);
		chk(32'(i_pmc_top.SYS_RESET_N), 32'h0);
		sup_ok <= 1'b1;
		repeat (2) @(posedge clk);
		chk(32'(i_pmc_top.SYS_RESET_N), 32'h1);
		v = rnd();
		pins <= v[7:0];
		apb(1'b1, pmc_pkg::ADDR_PORT_MATCH, 32'(v[7:0]));
		apb(1'b1, pmc_pkg::ADDR_PORT_MASK, 32'hFF);
		apb(1'b1, pmc_pkg::ADDR_WAKE_ENABLE, 32'h1);
		apb(1'b1, pmc_pkg::ADDR_POWER_CONTROL, 32'h1);
		pins <= v[7:0] ^ 8'h10;
		repeat (2) @(posedge clk);
		wait_mode(pmc_pkg::PMC_NORMAL);
		chk(32'(i_pmc_top.PORT_MATCH_IRQ), 32'h1);
		pins <= v[7:0];
		apb(1'b1, pmc_pkg::ADDR_STATUS, 32'h1000);
		apb(1'b0, pmc_pkg::ADDR_STATUS, 32'h0);
		chk(rdat, 32'h101);
		complete_run;
	end
endmodule
